// file: include/ccps_defs.vh
// constants for the codec clock and power sequencer
`ifndef CCPS_DEFS_VH
`define CCPS_DEFS_VH
`define CCPS_ADDR_POWER 8'h00
`define CCPS_ADDR_FORMAT 8'h01
`define CCPS_ADDR_PLLSEL 8'h02
`define CCPS_ADDR_LEVEL 8'h03
`define CCPS_ADDR_OVOL_L 8'h04
`define CCPS_ADDR_OVOL_R 8'h05
`define CCPS_ADDR_LEVEL_REFERENCE 8'h06
`define CCPS_ADDR_SPK 8'h07
`define CCPS_ADDR_INPUT_VOLUME_GAIN 8'h08
`define CCPS_ADDR_STATUS 8'h09
`define CCPS_PWR_COMMON_VOLTAGE_REF 0
`define CCPS_PWR_PLL 1
`define CCPS_PWR_ADCL 2
`define CCPS_PWR_ADCR 3
`define CCPS_PWR_DAC 4
`define CCPS_PWR_MASTER_CLOCK_OUT 6
`define CCPS_FMT_BITCLK_RATIO_SEL 6
`define CCPS_FMT_MASTER 7
`define CCPS_LVL_ALC 0
`define CCPS_LVL_PLAYBACK_LEVEL_ENABLE 1
`define CCPS_LVL_VLINK 2
`define CCPS_LVL_DAC_FILTER_PATH_SEL 3
`define CCPS_SPK_PATH 0
`define CCPS_SPK_PWR 3
`define CCPS_SPK_EXIT 4
`define CCPS_REF_FRAME 4'h0
`define CCPS_REF_BIT 4'h1
`define CCPS_LEVEL_RST 8'h04
`define CCPS_OVOL_DEF 8'h91
`define CCPS_INPUT_VOLUME_GAIN_DEF 8'he1
`define CCPS_MID_CODE 16'h8000
`define CCPS_CLK_MHZ 25'd100
`define CCPS_LOCK_MASTER_CLOCK_IN_MS 25'd40
`define CCPS_LOCK_FRAME_MS 25'd160
`define CCPS_LOCK_BIT_MS 25'd2
`define CCPS_MS_TO_CYC(ms) ((ms) * 25'd1000 * `CCPS_CLK_MHZ)
`define CCPS_ADC_INIT_FS 11'd1059
`define CCPS_DAC_MUTE_FS 11'd67
`define CCPS_ACT_TIMEOUT 16'hffff
`define CCPS_BCLK_HALF 8'd16
`define CCPS_MASTER_CLOCK_OUT_HALF 8'd4
`endif

// file: verilog/ccps_sequencer.v
// codec clock set-up and power sequencing core
//
// What this block does
// - dac samples are two's complement; zero maps to mid-scale level.
// - master mode: pll locks within 40ms after power with master clock present.
// - master mode: frame and bit clocks driven only after pll is stable.
// - master clock out: undefined before lock, proper clock after, when enabled.
// - slave pll lock: 160ms on frame clock, 2ms on bit clock reference.
// - external-clock mode runs once all three clocks arrive, no lock wait.
// - adc gives valid data 1059 sample periods after power up.
// - level control first starts from default input gain +30dB.
// - adc power down keeps input gain; next power-up resumes from it.
// - level control is idle while adc is powered down.
// - dac output undefined for 67 sample periods after power up.
// - linked volume sets both channels; volume ramps softly from 0dB default.
// - output level and volume idle while adc on and filter path bit 0.
// - chip reset low returns all control registers to defaults.
`timescale 1ns/10ps
`default_nettype none
`include "ccps_defs.vh"

module ccps_sequencer #(
	parameter [24:0] LOCK_MASTER_CLOCK_IN_CYC = `CCPS_MS_TO_CYC(`CCPS_LOCK_MASTER_CLOCK_IN_MS),
	parameter [24:0] LOCK_FRAME_CYC = `CCPS_MS_TO_CYC(`CCPS_LOCK_FRAME_MS),
	parameter [24:0] LOCK_BIT_CYC = `CCPS_MS_TO_CYC(`CCPS_LOCK_BIT_MS),
	parameter [15:0] ACT_TIMEOUT = `CCPS_ACT_TIMEOUT
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire master_clock_in,
	input wire frame_clock_in,
	output reg frame_clock_out,
	output wire frame_clock_oe,
	input wire bit_clock_in,
	output reg bit_clock_out,
	output wire bit_clock_oe,
	output reg master_clock_out,
	input wire [15:0] dac_sample,
	output reg [15:0] dac_level,
	output reg [7:0] dac_volume_l,
	output reg [7:0] dac_volume_r,
	input wire level_over,
	output reg adc_data_valid,
	output wire speaker_out_en,
	output wire normal_op
);

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	reg rst_s1_r, rst_s2_r;
	wire srst_n = rst_s2_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// pin synchronisers and activity detection: 0 master, 1 frame, 2 bit
	wire [2:0] pin_in = {bit_clock_in, frame_clock_in, master_clock_in};
	reg [2:0] sync1_r, sync2_r, sync3_r;
	wire [2:0] pin_rise = sync2_r & ~sync3_r;
	wire [2:0] act;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sync3_r <= 3'h0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_act
			reg [15:0] act_cnt_r;
			always @(posedge clk or negedge srst_n) begin
				if (!srst_n)
					act_cnt_r <= 16'h0;
				else if (pin_rise[gi])
					act_cnt_r <= ACT_TIMEOUT;
				else if (act_cnt_r != 16'h0)
					act_cnt_r <= act_cnt_r - 16'h1;
			end
			assign act[gi] = (act_cnt_r != 16'h0);
		end
	endgenerate

	// control registers, all back to defaults on chip reset
	reg [7:0] pwr_r, fmt_r, pllsel_r, lvl_r, ovol_l_r, ovol_r_r, level_reference_r, spk_r, input_volume_gain_r;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			pwr_r <= 8'h00;
			fmt_r <= 8'h00;
			pllsel_r <= 8'h00;
			lvl_r <= `CCPS_LEVEL_RST;
			ovol_l_r <= `CCPS_OVOL_DEF;
			ovol_r_r <= `CCPS_OVOL_DEF;
			level_reference_r <= `CCPS_INPUT_VOLUME_GAIN_DEF;
			spk_r <= 8'h00;
		end else if (reg_wr) begin
			if (hit(reg_addr, `CCPS_ADDR_POWER))
				pwr_r <= reg_wdata;
			if (hit(reg_addr, `CCPS_ADDR_FORMAT))
				fmt_r <= reg_wdata;
			if (hit(reg_addr, `CCPS_ADDR_PLLSEL))
				pllsel_r <= {4'h0, reg_wdata[3:0]};
			if (hit(reg_addr, `CCPS_ADDR_LEVEL))
				lvl_r <= {2'h0, reg_wdata[5:0]};
			if (hit(reg_addr, `CCPS_ADDR_OVOL_L))
				ovol_l_r <= reg_wdata;
			if (hit(reg_addr, `CCPS_ADDR_OVOL_R))
				ovol_r_r <= reg_wdata;
			if (hit(reg_addr, `CCPS_ADDR_LEVEL_REFERENCE))
				level_reference_r <= reg_wdata;
			if (hit(reg_addr, `CCPS_ADDR_SPK))
				spk_r <= {3'h0, reg_wdata[4:0]};
		end
	end

	wire common_voltage_ref = pwr_r[`CCPS_PWR_COMMON_VOLTAGE_REF];
	wire pll_pw = pwr_r[`CCPS_PWR_PLL];
	wire adc_pw = pwr_r[`CCPS_PWR_ADCL] | pwr_r[`CCPS_PWR_ADCR];
	wire dac_pw = pwr_r[`CCPS_PWR_DAC];
	wire master = fmt_r[`CCPS_FMT_MASTER];
	wire ref_frame = ~master & (pllsel_r[3:0] == `CCPS_REF_FRAME);
	wire ref_bit = ~master & (pllsel_r[3:0] == `CCPS_REF_BIT);

	// pll lock timing per reference
	reg [24:0] lock_cnt_r;
	reg locked_r;
	wire ref_ok = ref_frame ? act[1] : (ref_bit ? act[2] : act[0]);
	wire [24:0] lock_lim = ref_frame ? LOCK_FRAME_CYC : (ref_bit ? LOCK_BIT_CYC : LOCK_MASTER_CLOCK_IN_CYC);
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			lock_cnt_r <= 25'h0;
			locked_r <= 1'b0;
		end else if (!pll_pw || !common_voltage_ref) begin
			lock_cnt_r <= 25'h0;
			locked_r <= 1'b0;
		end else if (!locked_r && ref_ok) begin
			lock_cnt_r <= lock_cnt_r + 25'h1;
			if (lock_cnt_r + 25'h1 >= lock_lim)
				locked_r <= 1'b1;
		end
	end

	// normal operation: locked pll, or all three clocks in external mode
	assign normal_op = common_voltage_ref & (pll_pw ? locked_r : (&act));

	// master-mode clock generation
	reg [7:0] bdiv_r, mdiv_r;
	reg [5:0] bit_cnt_r;
	wire drive_clk = master & pll_pw & common_voltage_ref & locked_r;
	assign bit_clock_oe = drive_clk;
	assign frame_clock_oe = drive_clk;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			bdiv_r <= 8'h0;
			bit_cnt_r <= 6'h0;
			bit_clock_out <= 1'b0;
			frame_clock_out <= 1'b0;
		end else if (!drive_clk) begin
			bdiv_r <= 8'h0;
			bit_cnt_r <= 6'h0;
			bit_clock_out <= 1'b0;
			frame_clock_out <= 1'b0;
		end else if (bdiv_r == `CCPS_BCLK_HALF - 8'h1) begin
			bdiv_r <= 8'h0;
			bit_clock_out <= ~bit_clock_out;
			if (bit_clock_out) begin
				bit_cnt_r <= bit_cnt_r + 6'h1;
				frame_clock_out <= fmt_r[`CCPS_FMT_BITCLK_RATIO_SEL] ? bit_cnt_r[5] : bit_cnt_r[4];
			end
		end else
			bdiv_r <= bdiv_r + 8'h1;
	end

	// master clock out: fast free toggle before lock, divided clock after
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			mdiv_r <= 8'h0;
			master_clock_out <= 1'b0;
		end else if (!pwr_r[`CCPS_PWR_MASTER_CLOCK_OUT] || !pll_pw) begin
			mdiv_r <= 8'h0;
			master_clock_out <= 1'b0;
		end else if (!locked_r)
			master_clock_out <= ~master_clock_out;
		else if (mdiv_r == `CCPS_MASTER_CLOCK_OUT_HALF - 8'h1) begin
			mdiv_r <= 8'h0;
			master_clock_out <= ~master_clock_out;
		end else
			mdiv_r <= mdiv_r + 8'h1;
	end

	// one tick per sample period
	reg frame_d_r;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n)
			frame_d_r <= 1'b0;
		else
			frame_d_r <= frame_clock_out;
	end
	wire fs_tick = normal_op & (drive_clk ? (frame_clock_out & ~frame_d_r) : pin_rise[1]);

	// adc initialisation and dac mute counters
	wire adc_on = adc_pw & normal_op;
	wire dac_on = dac_pw & normal_op;
	reg [10:0] adc_cnt_r, dac_cnt_r;
	reg dac_valid_r;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			adc_cnt_r <= 11'h0;
			adc_data_valid <= 1'b0;
			dac_cnt_r <= 11'h0;
			dac_valid_r <= 1'b0;
		end else begin
			if (!adc_on) begin
				adc_cnt_r <= 11'h0;
				adc_data_valid <= 1'b0;
			end else if (fs_tick && !adc_data_valid) begin
				adc_cnt_r <= adc_cnt_r + 11'h1;
				if (adc_cnt_r + 11'h1 == `CCPS_ADC_INIT_FS)
					adc_data_valid <= 1'b1;
			end
			if (!dac_on) begin
				dac_cnt_r <= 11'h0;
				dac_valid_r <= 1'b0;
			end else if (fs_tick && !dac_valid_r) begin
				dac_cnt_r <= dac_cnt_r + 11'h1;
				if (dac_cnt_r + 11'h1 == `CCPS_DAC_MUTE_FS)
					dac_valid_r <= 1'b1;
			end
		end
	end

	// input level control; gain held across adc power-down
	wire alc_active = lvl_r[`CCPS_LVL_ALC] & adc_on;
	wire [7:0] attack = {6'h0, lvl_r[5:4]} + 8'h1;
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n)
			input_volume_gain_r <= `CCPS_INPUT_VOLUME_GAIN_DEF;
		else if (alc_active && fs_tick) begin
			if (level_over)
				input_volume_gain_r <= (input_volume_gain_r > attack) ? input_volume_gain_r - attack : 8'h0;
			else if (input_volume_gain_r < level_reference_r)
				input_volume_gain_r <= input_volume_gain_r + 8'h1;
		end
	end

	// dac data and soft volume ramp
	wire ovol_active = ~(adc_pw & ~lvl_r[`CCPS_LVL_DAC_FILTER_PATH_SEL]);
	wire [15:0] vol_tgt = {lvl_r[`CCPS_LVL_VLINK] ? ovol_l_r : ovol_r_r, ovol_l_r};
	wire [15:0] vol_cur = {dac_volume_r, dac_volume_l};
	wire [15:0] vol_nxt;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_vol
			wire [7:0] cur = vol_cur[gi*8 +: 8];
			wire [7:0] tgt = vol_tgt[gi*8 +: 8];
			assign vol_nxt[gi*8 +: 8] = (!dac_on) ? `CCPS_OVOL_DEF :
				(!ovol_active || !fs_tick || cur == tgt) ? cur :
				(cur < tgt) ? cur + 8'h1 : cur - 8'h1;
		end
	endgenerate
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			dac_volume_l <= `CCPS_OVOL_DEF;
			dac_volume_r <= `CCPS_OVOL_DEF;
			dac_level <= `CCPS_MID_CODE;
		end else begin
			dac_volume_l <= vol_nxt[7:0];
			dac_volume_r <= vol_nxt[15:8];
			dac_level <= dac_valid_r ? (dac_sample ^ `CCPS_MID_CODE) : `CCPS_MID_CODE;
		end
	end

	assign speaker_out_en = spk_r[`CCPS_SPK_PATH] & spk_r[`CCPS_SPK_PWR] & spk_r[`CCPS_SPK_EXIT] & dac_valid_r;

	// read port, data one cycle after the strobe
	wire [7:0] status = {2'h0, lvl_r[`CCPS_LVL_PLAYBACK_LEVEL_ENABLE] & ovol_active & dac_on, ovol_active,
		alc_active, dac_valid_r, adc_data_valid, normal_op};
	always @(posedge clk or negedge srst_n) begin
		if (!srst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`CCPS_ADDR_POWER: reg_rdata <= pwr_r;
				`CCPS_ADDR_FORMAT: reg_rdata <= fmt_r;
				`CCPS_ADDR_PLLSEL: reg_rdata <= pllsel_r;
				`CCPS_ADDR_LEVEL: reg_rdata <= lvl_r;
				`CCPS_ADDR_OVOL_L: reg_rdata <= ovol_l_r;
				`CCPS_ADDR_OVOL_R: reg_rdata <= ovol_r_r;
				`CCPS_ADDR_LEVEL_REFERENCE: reg_rdata <= level_reference_r;
				`CCPS_ADDR_SPK: reg_rdata <= spk_r;
				`CCPS_ADDR_INPUT_VOLUME_GAIN: reg_rdata <= input_volume_gain_r;
				`CCPS_ADDR_STATUS: reg_rdata <= status;
				default: reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

endmodule // ccps_sequencer
`default_nettype wire

// file: verilog/unused_placeholder_none.v
// no logic; intentionally empty design unit list
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: dv/ccps_clk_src.sv
// host-side audio clock source
`timescale 1ns/10ps
`default_nettype none
module ccps_clk_src(
	input wire logic run,
	output logic mclk,
	output logic bclk,
	output logic fclk
);
	int n = 0;
	initial mclk = 1'b0;
	initial bclk = 1'b0;
	initial fclk = 1'b0;
	// clocks stand still while idle
	always #17 mclk = run & ~mclk;
	// all three clocks supplied together
	always #23 begin
		bclk = run & ~bclk;
		if (run && !bclk)
			n = n + 1;
		if (n == 16) begin
			n = 0;
			fclk = ~fclk;
		end
		if (!run)
			fclk = 1'b0;
	end
endmodule // ccps_clk_src
`default_nettype wire

// file: dv/ccps_sequencer_properties.sv
// port assertions for the sequencer
`timescale 1ns/10ps
`default_nettype none
module ccps_chk(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic frame_clock_oe,
	input wire logic bit_clock_oe,
	input wire logic master_clock_out,
	input wire logic [15:0] dac_sample,
	input wire logic [15:0] dac_level,
	input wire logic [7:0] dac_volume_l,
	input wire logic [7:0] dac_volume_r,
	input wire logic normal_op
);
	logic [7:0] pw_r;
	logic [7:0] lv_r;
	logic ms_r;
	// shadow of power, level and master bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pw_r <= 8'h00;
			lv_r <= 8'h04;
			ms_r <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h00) pw_r <= reg_wdata;
			if (reg_addr == 8'h03) lv_r <= reg_wdata;
			if (reg_addr == 8'h01) ms_r <= reg_wdata[7];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_dac_off;
		!pw_r[4] [*3];
	endsequence
	sequence s_hold;
		(pw_r[4] && (pw_r[2] || pw_r[3]) && !lv_r[3] && $stable(pw_r) && $stable(lv_r)) [*2];
	endsequence
	a_slave_quiet: assert property (!ms_r |-> !frame_clock_oe && !bit_clock_oe)
		else $error("clock pins driven in slave mode");
	a_oe_locked: assert property (frame_clock_oe |-> normal_op)
		else $error("frame clock driven before lock");
	a_master_clock_out_off: assert property ((!pw_r[6] || !pw_r[1]) [*2] |-> !master_clock_out)
		else $error("master clock out active while disabled");
	a_dac_mid: assert property (s_dac_off |-> dac_level == 16'h8000)
		else $error("dac level not mid while off");
	a_dac_code: assert property (dac_level != 16'h8000 |-> dac_level == ($past(dac_sample) ^ 16'h8000))
		else $error("dac level code wrong");
	a_vol_link: assert property (lv_r[2] |-> dac_volume_l == dac_volume_r)
		else $error("linked volumes differ");
	a_vol_step: assert property (pw_r[4] && $past(pw_r[4]) && $changed(dac_volume_l)
		|-> 8'(dac_volume_l - $past(dac_volume_l)) inside {8'h01, 8'hff})
		else $error("volume jumped");
	a_vol_hold: assert property (s_hold |=> $stable(dac_volume_l))
		else $error("volume moved while bypassed");
	a_common_voltage_ref_first: assert property (normal_op |-> pw_r[0])
		else $error("running without common voltage");
endmodule // ccps_chk
bind ccps_sequencer ccps_chk i_chk(.*);
`default_nettype wire

// file: dv/test_ccps_sequencer.sv
// self-checking bench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module test_ccps_sequencer;
	logic clk, rst_n, reg_wr, reg_rd, level_over, run, mck, bck, fck, fcoe, bcoe, nop, p, spk, adv, bco;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, vol_l, vol_r;
	logic [15:0] dac_sample, dac_level;
	int num_errors, n_tests, i, k;
	localparam logic [15:0] DEFS [8] = '{16'h0000, 16'h0304, 16'h0491, 16'h0591, 16'h06e1, 16'h08e1,
		16'h0910, 16'h2000};
	localparam logic [31:0] SMP [3] = '{32'h8000_0000, 32'h0000_8000, 32'h0001_8001};
	ccps_sequencer #(.LOCK_MASTER_CLOCK_IN_CYC(25'd100), .LOCK_FRAME_CYC(25'd200), .LOCK_BIT_CYC(25'd50),
		.ACT_TIMEOUT(16'd400)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.master_clock_in(mck), .frame_clock_in(fck), .frame_clock_out(), .frame_clock_oe(fcoe),
		.bit_clock_in(bck), .bit_clock_out(bco), .bit_clock_oe(bcoe), .master_clock_out(),
		.dac_sample(dac_sample), .dac_level(dac_level), .dac_volume_l(vol_l),
		.dac_volume_r(vol_r), .level_over(level_over), .adc_data_valid(adv), .speaker_out_en(spk),
		.normal_op(nop));
	ccps_clk_src i_src (.run(run), .mclk(mck), .bclk(bck), .fclk(fck));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (15) @(posedge clk);
		rst_n <= 1'b1;
		cyc(3);
	endtask
	task relock(input logic [7:0] sel, input logic [7:0] pw);
		wr(8'h00, 8'h01);
		wr(8'h02, sel);
		wr(8'h00, pw);
		cyc(1);
		for (k = 1; k < 600 && nop !== 1'b1; k++) cyc(1);
	endtask
	task t_defaults;
		wr(8'h03, 8'hff);
		rd(8'h03);
		chk(d, 8'h3f);
		do_reset;
		for (i = 0; i < 8; i++) begin
			rd(DEFS[i][15:8]);
			chk(d, DEFS[i][7:0]);
		end
		chk(dac_level, 16'h8000);
		chk(vol_l, 8'h91);
		wr(8'h08, 8'h00);
		rd(8'h08);
		chk(d, 8'he1);
	endtask
	task t_ext;
		run <= 1'b1;
		cyc(300);
		chk(nop, 1'b0);
		wr(8'h00, 8'h01);
		for (i = 0; i < 400 && nop !== 1'b1; i++) cyc(1);
		chk(nop, 1'b1);
		chk(fcoe | bcoe, 1'b0);
	endtask
	task t_dac;
		wr(8'h04, 8'ha0);
		dac_sample <= 16'h7fff;
		wr(8'h00, 8'h11);
		k = 0;
		p = fck;
		for (i = 0; i < 12000 && dac_level === 16'h8000; i++) begin
			cyc(1);
			if (fck && !p) k++;
			p = fck;
		end
		chk(k >= 66 && k <= 68, 1'b1);
		chk(dac_level, 16'hffff);
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			dac_sample <= SMP[i][31:16];
			cyc(3);
			chk(dac_level, SMP[i][15:0]);
		end
		for (i = 0; i < 4000 && vol_l !== 8'ha0; i++) cyc(1);
		chk({vol_l, vol_r}, 16'ha0a0);
		wr(8'h07, 8'h01);
		wr(8'h07, 8'h03);
		wr(8'h07, 8'h0b);
		cyc(1);
		chk(spk, 1'b0);
		wr(8'h07, 8'h1b);
		cyc(1);
		chk(spk, 1'b1);
		wr(8'h07, 8'h0b);
		wr(8'h07, 8'h0a);
		wr(8'h07, 8'h02);
		cyc(1);
		chk(spk, 1'b0);
	endtask
	task t_hold;
		wr(8'h00, 8'h15);
		wr(8'h04, 8'h80);
		cyc(1500);
		chk(vol_l, 8'ha0);
		wr(8'h03, 8'h0c);
		cyc(6000);
		chk(vol_l, 8'h80);
	endtask
	task t_alc;
		@(posedge clk);
		level_over <= 1'b1;
		wr(8'h00, 8'h31);
		wr(8'h03, 8'h0d);
		cyc(600);
		rd(8'h08);
		chk(d, 8'he1);
		rd(8'h09);
		chk(d[3], 1'b0);
		wr(8'h00, 8'h3d);
		cyc(900);
		rd(8'h09);
		chk(d[3], 1'b1);
		chk(d[1], 1'b0);
		chk(adv, 1'b0);
		wr(8'h00, 8'h31);
		rd(8'h08);
		k = d;
		chk(d < 8'he1, 1'b1);
		cyc(900);
		rd(8'h08);
		chk(d, k[7:0]);
	endtask
	task t_pll;
		do_reset;
		wr(8'h01, 8'h80);
		wr(8'h02, 8'h02);
		wr(8'h00, 8'h43);
		for (k = 0; k < 300 && nop !== 1'b1; k++) cyc(1);
		chk(k >= 95 && k <= 108, 1'b1);
		chk({fcoe, bcoe}, 2'b11);
		k = 0;
		p = bco;
		for (i = 0; i < 320; i++) begin
			cyc(1);
			if (bco && !p) k++;
			p = bco;
		end
		chk(k >= 9 && k <= 11, 1'b1);
	endtask
	task t_slave;
		wr(8'h01, 8'h00);
		relock(8'h01, 8'h03);
		chk(k >= 48 && k <= 52, 1'b1);
		chk({fcoe, bcoe}, 2'b00);
		relock(8'h00, 8'h03);
		chk(k >= 198 && k <= 202, 1'b1);
		relock(8'h02, 8'h43);
		chk(k >= 98 && k <= 102, 1'b1);
	endtask
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		level_over = 1'b0;
		run = 1'b0;
		dac_sample = 16'h0000;
		num_errors = 0;
		n_tests = 0;
		do_reset;
		t_defaults;
		t_ext;
		t_dac;
		t_hold;
		t_alc;
		t_pll;
		t_slave;
		test_done;
	end
endmodule // test_ccps_sequencer
`default_nettype wire
